/* File: core/isc_chan.sv */
// One interrupt channel: polarity, trigger mode and edge latch
`timescale 1ns/1ps
module isc_chan (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic req_i,
	input  wire logic edge_i,
	input  wire logic high_i,
	input  wire logic clr_i,
	output logic      pend_o
);
	logic act;
	logic prev_q;
	logic latch_q;
	logic latch_d;
	logic rise;
	logic armed_q;

	assign act  = high_i ? req_i : ~req_i;
	// No edge is seen until prev_q has taken the real level once after reset
	assign rise = act & ~prev_q & armed_q;
	// A new edge in the clear cycle wins over the clear
	assign latch_d = rise | (latch_q & ~clr_i);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_q  <= 1'b0;
			latch_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
			prev_q  <= act;
			latch_q <= edge_i ? latch_d : 1'b0;
		end
	end

	assign pend_o = edge_i ? latch_q : act;

	chk_edge_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(edge_i && $past(edge_i) && $past(latch_q) && !$past(clr_i)) |-> pend_o)
		else $error("edge latch lost without clear");
	chk_edge_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(edge_i && $past(edge_i) && $past(clr_i) && !$past(rise)) |-> !pend_o)
		else $error("edge latch not cleared");
	chk_level_live: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!edge_i |-> (pend_o == (req_i == high_i)))
		else $error("level pending not live");
endmodule : isc_chan

/* File: core/isc_pkg.sv */
// Package of constants for the interrupt status combiner
package isc_pkg;
	localparam int          ISC_NCH        = 13;
	localparam int          ISC_NEXT       = 6;
	localparam int          ISC_WDOG_CH    = 12;
	localparam logic [7:0]  ISC_OFS_CFG0   = 8'h00;
	localparam logic [7:0]  ISC_OFS_CFG1   = 8'h04;
	localparam logic [7:0]  ISC_OFS_CLR    = 8'h08;
	localparam logic [7:0]  ISC_OFS_NEN    = 8'h0C;
	localparam logic [7:0]  ISC_OFS_FEN    = 8'h10;
	localparam logic [7:0]  ISC_OFS_NSTAT  = 8'h14;
	localparam logic [7:0]  ISC_OFS_FSTAT  = 8'h18;
	localparam logic [7:0]  ISC_OFS_PEND   = 8'h1C;
	localparam logic [15:0] ISC_CFG0_MASK  = 16'h0FFF;
	localparam logic [7:0]  ISC_CFG1_MASK  = 8'h07;
	localparam logic [15:0] ISC_NEN_MASK   = 16'h0FFF;
	localparam logic [15:0] ISC_FEN_MASK   = 16'h0FFF;
	localparam logic [15:0] ISC_CLR_MASK   = 16'h03FF;
	localparam logic [15:0] ISC_CFG0_RST   = 16'h0000;
	localparam logic [7:0]  ISC_CFG1_RST   = 8'h00;
	localparam logic [15:0] ISC_EN_RST     = 16'h0000;
	localparam int          ISC_CLR_WDOG_BIT = 9;
	localparam int          ISC_CLR_CH8_BIT  = 8;
endpackage : isc_pkg

/* File: core/isc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module isc_sync (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign sync_o = out_q;
endmodule : isc_sync

/* File: core/isc_top.sv */
// Interrupt status combiner with APB register slave
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module isc_top
	import isc_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	input  wire logic [isc_pkg::ISC_NEXT-1:0] ext_irq_i,
	input  wire logic [2:0]           timer_irq_i,
	input  wire logic [2:0]           serial_irq_i,
	input  wire logic                 watchdog_irq_i,
	output logic                      fast_interrupt_line_o,
	output logic                      normal_interrupt_line_o
);
	import isc_pkg::*;

	logic [15:0]        cfg0_q;
	logic [7:0]         cfg1_q;
	logic [15:0]        nen_q;
	logic [15:0]        fen_q;
	logic [ISC_NCH-1:0] req_raw;
	logic [ISC_NCH-1:0] req;
	logic [ISC_NCH-1:0] edge_sel;
	logic [ISC_NCH-1:0] high_sel;
	logic [ISC_NCH-1:0] clr_ch;
	logic [ISC_NCH-1:0] pend;
	logic [ISC_NCH-1:0] nmask;
	logic [ISC_NCH-1:0] fmask;
	logic [15:0]        normal_interrupt_status;
	logic [15:0]        fast_interrupt_status;
	logic [15:0]        pending_poll;
	logic               acc;
	logic               wr;
	logic               hit;
	logic [15:0]        rd_mux;
	logic [15:0]        edge_clear;

	assign req_raw = {watchdog_irq_i, serial_irq_i, timer_irq_i, ext_irq_i};

	// Pins pass the synchroniser; internal sources are on this clock
	genvar gi;
	generate
		for (gi = 0; gi < ISC_NEXT; gi++) begin : g_sync
			isc_sync u_sync (
				.sys_clk_i (sys_clk_i),
				.rstn_i    (rstn_i),
				.async_i   (ext_irq_i[gi]),
				.sync_o    (req[gi])
			);
		end
	endgenerate
	assign req[ISC_NCH-1:ISC_NEXT] = req_raw[ISC_NCH-1:ISC_NEXT];

	// Trigger and polarity per channel group; pins set by cfg0_q, timer polarity by cfg1_q
	assign edge_sel = {1'b1, 3'b000, 3'b111,
		cfg0_q[11], cfg0_q[9], cfg0_q[7], cfg0_q[5], cfg0_q[3], cfg0_q[1]};
	assign high_sel = {1'b1, 3'b111, cfg1_q[2:0],
		cfg0_q[10], cfg0_q[8], cfg0_q[6], cfg0_q[4], cfg0_q[2], cfg0_q[0]};

	// APB decode, zero-wait slave
	assign acc = psel_i & penable_i;
	assign wr  = acc & pwrite_i;
	assign hit = (paddr_i[1:0] == 2'b00) && (paddr_i <= ISC_OFS_PEND);
	assign pready_o  = 1'b1;
	assign pslverr_o = acc & ~hit;

	assign edge_clear = (wr && paddr_i == ISC_OFS_CLR) ? (pwdata_i[15:0] & ISC_CLR_MASK)
		: 16'h0000;
	assign clr_ch = {edge_clear[ISC_CLR_WDOG_BIT], 3'b000,
		edge_clear[ISC_CLR_CH8_BIT:0]};

	generate
		for (gi = 0; gi < ISC_NCH; gi++) begin : g_chan
			isc_chan u_chan (
				.sys_clk_i (sys_clk_i),
				.rstn_i    (rstn_i),
				.req_i     (req[gi]),
				.edge_i    (edge_sel[gi]),
				.high_i    (high_sel[gi]),
				.clr_i     (clr_ch[gi]),
				.pend_o    (pend[gi])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg0_q <= ISC_CFG0_RST;
			cfg1_q <= ISC_CFG1_RST;
			nen_q  <= ISC_EN_RST;
			fen_q  <= ISC_EN_RST;
		end else if (wr) begin
			// Status and pending offsets fall through: writes ignored
			case (paddr_i)
				ISC_OFS_CFG0: cfg0_q <= pwdata_i[15:0] & ISC_CFG0_MASK;
				ISC_OFS_CFG1: cfg1_q <= pwdata_i[7:0] & ISC_CFG1_MASK;
				ISC_OFS_NEN:  nen_q  <= pwdata_i[15:0] & ISC_NEN_MASK;
				ISC_OFS_FEN:  fen_q  <= pwdata_i[15:0] & ISC_FEN_MASK;
				default: ;
			endcase
		end
	end

	// Masks; channel 12 forced onto the fast line, never the normal one
	assign nmask = {1'b0, nen_q[11:0]};
	assign fmask = {1'b1, fen_q[11:0]};

	assign pending_poll            = {3'b000, pend};
	assign normal_interrupt_status = {3'b000, pend & nmask};
	assign fast_interrupt_status   = {3'b000, pend & fmask};

	// Plain OR, no ranking; the core ranks the two lines itself
	assign fast_interrupt_line_o   = |fast_interrupt_status;
	assign normal_interrupt_line_o = |normal_interrupt_status;

	always_comb begin
		rd_mux = 16'h0000;
		case (paddr_i)
			ISC_OFS_CFG0:  rd_mux = cfg0_q;
			ISC_OFS_CFG1:  rd_mux = {8'h00, cfg1_q};
			ISC_OFS_NEN:   rd_mux = nen_q;
			ISC_OFS_FEN:   rd_mux = fen_q;
			ISC_OFS_NSTAT: rd_mux = normal_interrupt_status;
			ISC_OFS_FSTAT: rd_mux = fast_interrupt_status;
			ISC_OFS_PEND:  rd_mux = pending_poll;
			default:       rd_mux = 16'h0000;
		endcase
	end
	assign prdata_o = (acc && !pwrite_i) ? {16'h0000, rd_mux} : 32'h0000_0000;

	chk_wdog_fast: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend[ISC_WDOG_CH] |-> fast_interrupt_line_o && fast_interrupt_status[12])
		else $error("watchdog not on fast line");
	chk_norm_status: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		normal_interrupt_status[11:0] == (pending_poll[11:0] & nen_q[11:0]))
		else $error("normal status mismatch");
	chk_fast_status: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		fast_interrupt_status[11:0] == (pending_poll[11:0] & fen_q[11:0]))
		else $error("fast status mismatch");
	chk_norm_nowdog: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		normal_interrupt_status[15:12] == 4'h0)
		else $error("normal status shows watchdog");
	chk_pend_upper: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pending_poll[15:13] == 3'b000 && fast_interrupt_status[15:13] == 3'b000)
		else $error("reserved bits set");
	chk_line_or: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		normal_interrupt_line_o == ((pend[11:0] & nen_q[11:0]) != 12'h000))
		else $error("normal line not OR of status");
	chk_ro_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(wr && paddr_i == ISC_OFS_NSTAT) |=> ($stable(nen_q) && $stable(fen_q)
		&& $stable(cfg0_q)))
		else $error("status write changed state");
	chk_serial_level: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend[11:9] == serial_irq_i)
		else $error("serial channel not level high");
	chk_timer_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(clr_ch[6] && !pend[6]) |=> !pend[6] || (timer_irq_i[0] == cfg1_q[0]))
		else $error("timer clear failed");
	chk_pready_high: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pready_o)
		else $error("slave inserted a wait state");
	chk_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!(psel_i && penable_i && !pwrite_i) |-> (prdata_o == 32'h0000_0000))
		else $error("read data outside read access");
	chk_fast_or: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		fast_interrupt_line_o == (fast_interrupt_status != 16'h0000))
		else $error("fast line not OR of status");
endmodule : isc_top

/* File: verif/interrupt_status_combiner_tb.sv */
// Self-checking bench for the interrupt status combiner
`timescale 1ns/1ps
module interrupt_status_combiner_tb;
	import isc_pkg::*;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, fast, norm, e, wd;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, vec, r;
	logic [5:0]  ext;
	logic [2:0]  tmr, ser;
	int          errors, compares, ticks;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	isc_top dut (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .ext_irq_i(ext), .timer_irq_i(tmr),
		.serial_irq_i(ser), .watchdog_irq_i(wd), .fast_interrupt_line_o(fast),
		.normal_interrupt_line_o(norm));
	isc_core_model core (.fast_i(fast), .norm_i(norm), .vec_o(vec));

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000);
		chk($sformatf("reg %h", a), r, x);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic close_out;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Cuts a hung handshake short
	always @(posedge clk) begin
		ticks++;
		if (ticks == 3000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		errors = 0;
		compares = 0;
		ticks = 0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ext = 6'h3F;
		tmr = 3'h0;
		ser = 3'h0;
		wd = 1'b0;
		cyc(16);
		rstn <= 1'b1;
		cyc(8);
		rd(ISC_OFS_CFG0, 32'h00000000);
		rd(ISC_OFS_FEN, 32'h00000000);
		apb(1'b1, ISC_OFS_CLR, 32'h000003FF);
		rd(ISC_OFS_PEND, 32'h00000000);
		wd <= 1'b1;
		cyc(2);
		wd <= 1'b0;
		cyc(2);
		chk("vector", vec, 32'h0000001C);
		rd(ISC_OFS_NSTAT, 32'h00000000);
		rd(ISC_OFS_FSTAT, 32'h00001000);
		rd(ISC_OFS_PEND, 32'h00001000);
		apb(1'b1, ISC_OFS_CLR, 32'h00000200);
		rd(ISC_OFS_PEND, 32'h00000000);
		chk("vector", vec, 32'h00000000);
		ser <= 3'h1;
		cyc(2);
		rd(ISC_OFS_PEND, 32'h00000200);
		rd(ISC_OFS_NSTAT, 32'h00000000);
		apb(1'b1, ISC_OFS_NEN, 32'h00000200);
		rd(ISC_OFS_NSTAT, 32'h00000200);
		chk("vector", vec, 32'h00000018);
		apb(1'b1, ISC_OFS_CLR, 32'h000003FF);
		rd(ISC_OFS_PEND, 32'h00000200);
		ser <= 3'h0;
		apb(1'b1, ISC_OFS_CFG1, 32'h00000001);
		rd(ISC_OFS_PEND, 32'h00000000);
		tmr <= 3'h1;
		cyc(2);
		tmr <= 3'h0;
		cyc(2);
		rd(ISC_OFS_PEND, 32'h00000040);
		apb(1'b1, ISC_OFS_FEN, 32'h00000040);
		rd(ISC_OFS_FSTAT, 32'h00000040);
		ser <= 3'h1;
		cyc(2);
		rd(ISC_OFS_PEND, 32'h00000240);
		chk("vector", vec, 32'h0000001C);
		ser <= 3'h0;
		apb(1'b1, ISC_OFS_CLR, 32'h00000040);
		rd(ISC_OFS_FSTAT, 32'h00000000);
		apb(1'b1, ISC_OFS_CFG0, 32'h00000004);
		cyc(6);
		rd(ISC_OFS_PEND, 32'h00000002);
		apb(1'b1, ISC_OFS_PEND, 32'h0000FFFF);
		rd(ISC_OFS_PEND, 32'h00000002);
		rd(8'h20, 32'h00000000);
		chk("slverr", {31'h0, e}, 32'h00000001);
		chk("pready", {31'h0, pready}, 32'h00000001);
		chk("prdata idle", prdata, 32'h00000000);
		close_out();
	end
endmodule : interrupt_status_combiner_tb

/* File: verif/isc_core_model.sv */
// Core-side model that ranks the two interrupt lines into a vector
`timescale 1ns/1ps
module isc_core_model #(
	parameter logic [31:0] FAST_VEC = 32'h0000001C,
	parameter logic [31:0] NORM_VEC = 32'h00000018
) (
	input  wire logic        fast_i,
	input  wire logic        norm_i,
	output logic      [31:0] vec_o
);
	// Fast line wins whenever both are raised
	assign vec_o = fast_i ? FAST_VEC : (norm_i ? NORM_VEC : 32'h00000000);
endmodule : isc_core_model
